// ==== include/adc_readout_pkg.sv ====
// Purpose: Shared constants and types for the conversion result read-back bank.
// Assumes: 16-bit serial frames, one address byte followed by one data byte.
// Notes: Offsets are byte addresses on the serial control port.
package adc_readout_pkg;

    // Widths
    localparam int SAMPLE_W = 24;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 7;
    localparam int CHAN_N = 5;

    // Channel slots inside the result array
    localparam int CH_I1 = 0;
    localparam int CH_V1 = 1;
    localparam int CH_I2 = 2;
    localparam int CH_V2 = 3;
    localparam int CH_I3 = 4;

    // Offsets in the full map
    localparam logic [6:0] OFF_I1_HIGH = 7'h05;
    localparam logic [6:0] OFF_I1_MID = 7'h06;
    localparam logic [6:0] OFF_I1_LOW = 7'h07;
    localparam logic [6:0] OFF_V1_TAG = 7'h08;
    localparam logic [6:0] OFF_V1_HIGH = 7'h09;
    localparam logic [6:0] OFF_V1_MID = 7'h0A;
    localparam logic [6:0] OFF_V1_LOW = 7'h0B;
    localparam logic [6:0] OFF_I2_TAG = 7'h0C;
    localparam logic [6:0] OFF_I2_HIGH = 7'h0D;
    localparam logic [6:0] OFF_I2_MID = 7'h0E;
    localparam logic [6:0] OFF_I2_LOW = 7'h0F;
    localparam logic [6:0] OFF_V2_TAG = 7'h10;
    localparam logic [6:0] OFF_V2_HIGH = 7'h11;
    localparam logic [6:0] OFF_V2_MID = 7'h12;
    localparam logic [6:0] OFF_V2_LOW = 7'h13;
    localparam logic [6:0] OFF_I3_TAG = 7'h14;
    localparam logic [6:0] OFF_I3_HIGH = 7'h15;
    localparam logic [6:0] OFF_I3_MID = 7'h16;

    // Offsets in the compacted map
    localparam logic [6:0] CMP_I1_HIGH = 7'h02;
    localparam logic [6:0] CMP_I1_MID = 7'h03;
    localparam logic [6:0] CMP_V1_HIGH = 7'h04;
    localparam logic [6:0] CMP_V1_MID = 7'h05;
    localparam logic [6:0] CMP_I2_HIGH = 7'h06;
    localparam logic [6:0] CMP_I2_MID = 7'h07;
    localparam logic [6:0] CMP_V2_HIGH = 7'h08;
    localparam logic [6:0] CMP_V2_MID = 7'h09;
    localparam logic [6:0] CMP_I3_HIGH = 7'h0A;
    localparam logic [6:0] CMP_I3_MID = 7'h0B;

    // Fixed tag values
    localparam logic [7:0] voltage1_tag_value = 8'h03;
    localparam logic [7:0] current2_tag_value = 8'h04;
    localparam logic [7:0] voltage2_tag_value = 8'h05;
    localparam logic [7:0] current3_tag_value = 8'h06;

    // Reset values and serial framing
    localparam logic [23:0] RESULT_RESET = 24'h000000;
    localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
    localparam logic [2:0] PIN_IDLE = 3'b010;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam int WRITE_BIT = 7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_DONE = 4'b1000
    } link_state_t;

endpackage : adc_readout_pkg

// ==== logic/result_hold.sv ====
// Purpose: Holds one channel's conversion result and splits it into bytes.
// Assumes: load is a one-cycle strobe from logic on the same clock.
// Notes: Reading the bytes never disturbs the held value.
`timescale 1ns/1ps
module result_hold
    import adc_readout_pkg::*;
#(
    parameter logic [23:0] RESET_VAL = RESULT_RESET
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [23:0] sample_in,
    output logic [7:0] byte_high,
    output logic [7:0] byte_mid,
    output logic [7:0] byte_low
);

    logic [23:0] sample_reg;

    // Only reset or a new conversion updates the held value
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sample_reg <= RESET_VAL;
        end else if (load) begin
            sample_reg <= sample_in;
        end
    end

    // Byte split of the held result
    assign byte_high = sample_reg[23:16];
    assign byte_mid = sample_reg[15:8];
    assign byte_low = sample_reg[7:0];

endmodule : result_hold

// ==== logic/adc_result_readout.sv ====
// Purpose: Read-only result bank answering on the serial control port.
// Assumes: Clock mode 1 framing, address byte then data byte, pins are asynchronous.
// Notes: compact_mode comes from the configuration logic outside this block.
//
// Overview of operation
// - Results split into high, middle, low bytes
// - Low byte returns sample bits seven to zero
// - Voltage channel 1 tag reads three
// - Current channel 2 tag reads four
// - Voltage channel 2 tag reads five
// - Current channel 3 tag reads six
// - Compaction mode hides all tag registers
// - High and middle offsets depend on mode
// - Compacted high and middle bytes start 0x02
// - Compaction mode hides all low bytes
`timescale 1ns/1ps
module adc_result_readout
    import adc_readout_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe,
    input wire logic compact_mode,
    input wire logic [4:0] sample_load,
    input wire logic [23:0] current1_sample,
    input wire logic [23:0] voltage1_sample,
    input wire logic [23:0] current2_sample,
    input wire logic [23:0] voltage2_sample,
    input wire logic [23:0] current3_sample
);

    // Pin order in the sync vectors: {mosi, select_n, sclk}
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic [2:0] pin_reg;
    logic [2:0] pin_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;

    link_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [7:0] addr_reg;
    logic addr_done_reg;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic miso_reg;
    logic oe_reg;

    logic [23:0] sample_in [CHAN_N];
    logic [7:0] res_high [CHAN_N];
    logic [7:0] res_mid [CHAN_N];
    logic [7:0] res_low [CHAN_N];

    // Three-stage synchroniser for the serial pins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_reg <= PIN_IDLE;
            sync2_reg <= PIN_IDLE;
            sync3_reg <= PIN_IDLE;
        end else begin
            sync1_reg <= {mosi, select_n, sclk};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A pin level counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_reg <= PIN_IDLE;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pin_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    // Previous filtered level, for edge detection
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_prev_reg <= PIN_IDLE;
        end else begin
            pin_prev_reg <= pin_reg;
        end
    end

    // Edges of the filtered clock pin
    assign sclk_rise = pin_reg[0] & ~pin_prev_reg[0];
    assign sclk_fall = ~pin_reg[0] & pin_prev_reg[0];
    assign selected = ~pin_reg[1];

    // Assemble the sample array for the result holders
    assign sample_in[CH_I1] = current1_sample;
    assign sample_in[CH_V1] = voltage1_sample;
    assign sample_in[CH_I2] = current2_sample;
    assign sample_in[CH_V2] = voltage2_sample;
    assign sample_in[CH_I3] = current3_sample;

    // One result holder per channel
    for (genvar g = 0; g < CHAN_N; g++) begin : gen_chan
        result_hold #(
            .RESET_VAL(RESULT_RESET)
        ) u_hold (
            .clk(clk),
            .resetn(resetn),
            .load(sample_load[g]),
            .sample_in(sample_in[g]),
            .byte_high(res_high[g]),
            .byte_mid(res_mid[g]),
            .byte_low(res_low[g])
        );
    end

    // Frame sequencer; deselect aborts any frame at once
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
        end else if (!selected) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_ADDR;
                end
                ST_ADDR: begin
                    if (sclk_fall && bit_cnt_reg == LAST_BIT) begin
                        state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (sclk_rise && bit_cnt_reg == LAST_BIT) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_DONE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Bit counter, advanced on falling edges for address, rising for data
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bit_cnt_reg <= 4'h0;
        end else if (state_reg == ST_IDLE) begin
            bit_cnt_reg <= 4'h0;
        end else if (state_reg == ST_ADDR && sclk_fall) begin
            bit_cnt_reg <= (bit_cnt_reg == LAST_BIT) ? 4'h0 : bit_cnt_reg + 4'h1;
        end else if (state_reg == ST_DATA && sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // Address byte, MSB first, mosi taken on the falling edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shift_reg <= 7'h00;
            addr_reg <= 8'h00;
        end else if (state_reg == ST_ADDR && sclk_fall) begin
            shift_reg <= {shift_reg[5:0], pin_reg[2]};
            if (bit_cnt_reg == LAST_BIT) begin
                addr_reg <= {shift_reg, pin_reg[2]};
            end
        end
    end

    // One-cycle pulse once the address byte is complete
    always_ff @(posedge clk) begin
        if (!resetn) begin
            addr_done_reg <= 1'b0;
        end else begin
            addr_done_reg <= selected && state_reg == ST_ADDR && sclk_fall
                && bit_cnt_reg == LAST_BIT;
        end
    end

    // Read decode; pure mux, so a read leaves every holder untouched
    // side-effect free read
    always_comb begin
        tx_next = UNMAPPED_BYTE;
        if (addr_reg[WRITE_BIT]) begin
            tx_next = UNMAPPED_BYTE;
        end else if (compact_mode) begin
            case (addr_reg[6:0])
                CMP_I1_HIGH: tx_next = res_high[CH_I1];
                CMP_I1_MID: tx_next = res_mid[CH_I1];
                CMP_V1_HIGH: tx_next = res_high[CH_V1];
                CMP_V1_MID: tx_next = res_mid[CH_V1];
                CMP_I2_HIGH: tx_next = res_high[CH_I2];
                CMP_I2_MID: tx_next = res_mid[CH_I2];
                CMP_V2_HIGH: tx_next = res_high[CH_V2];
                CMP_V2_MID: tx_next = res_mid[CH_V2];
                CMP_I3_HIGH: tx_next = res_high[CH_I3];
                CMP_I3_MID: tx_next = res_mid[CH_I3];
                default: tx_next = UNMAPPED_BYTE;
            endcase
        end else begin
            case (addr_reg[6:0])
                OFF_I1_HIGH: tx_next = res_high[CH_I1];
                OFF_I1_MID: tx_next = res_mid[CH_I1];
                OFF_I1_LOW: tx_next = res_low[CH_I1];
                OFF_V1_TAG: tx_next = voltage1_tag_value;
                OFF_V1_HIGH: tx_next = res_high[CH_V1];
                OFF_V1_MID: tx_next = res_mid[CH_V1];
                OFF_V1_LOW: tx_next = res_low[CH_V1];
                OFF_I2_TAG: tx_next = current2_tag_value;
                OFF_I2_HIGH: tx_next = res_high[CH_I2];
                OFF_I2_MID: tx_next = res_mid[CH_I2];
                OFF_I2_LOW: tx_next = res_low[CH_I2];
                OFF_V2_TAG: tx_next = voltage2_tag_value;
                OFF_V2_HIGH: tx_next = res_high[CH_V2];
                OFF_V2_MID: tx_next = res_mid[CH_V2];
                OFF_V2_LOW: tx_next = res_low[CH_V2];
                OFF_I3_TAG: tx_next = current3_tag_value;
                OFF_I3_HIGH: tx_next = res_high[CH_I3];
                OFF_I3_MID: tx_next = res_mid[CH_I3];
                default: tx_next = UNMAPPED_BYTE;
            endcase
        end
    end

    // Transmit byte captured once, so a result update mid-byte cannot tear it
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_reg <= 8'h00;
        end else if (addr_done_reg) begin
            tx_reg <= tx_next;
        end else if (state_reg == ST_DATA && sclk_rise) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // Mode 1: drive the next bit on each rising edge of the data byte
    always_ff @(posedge clk) begin
        if (!resetn) begin
            miso_reg <= 1'b0;
        end else if (state_reg == ST_DATA && sclk_rise) begin
            miso_reg <= tx_reg[7];
        end else if (state_reg == ST_IDLE) begin
            miso_reg <= 1'b0;
        end
    end

    // Drive the data pin only while selected
    always_ff @(posedge clk) begin
        if (!resetn) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= selected;
        end
    end

    assign miso_o = miso_reg;
    assign miso_oe = oe_reg;

    // Checks, sampled on the system clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence read_taken(logic [6:0] off);
        addr_done_reg && !addr_reg[WRITE_BIT] && addr_reg[6:0] == off;
    endsequence

    sequence full_read(logic [6:0] off);
        read_taken(off) && !compact_mode;
    endsequence

    sequence compact_read(logic [6:0] off);
        read_taken(off) && compact_mode;
    endsequence

    chk_split_high: assert property (
        sample_load[CH_I1] |=> res_high[CH_I1] == $past(current1_sample[23:16])
            && res_mid[CH_I1] == $past(current1_sample[15:8]))
        else $error("high or middle byte not taken from the sample");

    chk_low_byte: assert property (
        full_read(OFF_V1_LOW) |=> tx_reg == res_low[CH_V1])
        else $error("low byte read does not match sample bits 7..0");

    chk_tag_v1: assert property (
        full_read(OFF_V1_TAG) |=> tx_reg == 8'h03)
        else $error("voltage 1 tag is not 3");

    chk_tag_i2: assert property (
        full_read(OFF_I2_TAG) |=> tx_reg == 8'h04)
        else $error("current 2 tag is not 4");

    chk_tag_v2: assert property (
        full_read(OFF_V2_TAG) |=> tx_reg == 8'h05)
        else $error("voltage 2 tag is not 5");

    chk_tag_i3: assert property (
        full_read(OFF_I3_TAG) |=> tx_reg == 8'h06)
        else $error("current 3 tag is not 6");

    chk_compact_tags: assert property (
        compact_read(OFF_I3_TAG) or compact_read(OFF_V2_TAG)
            |=> tx_reg == 8'h00)
        else $error("tag reachable in compaction mode");

    chk_mode_offset: assert property (
        full_read(OFF_V1_HIGH) |=> tx_reg == res_high[CH_V1])
        else $error("full map high byte misplaced");

    chk_compact_start: assert property (
        compact_read(CMP_I1_HIGH) |=> tx_reg == res_high[CH_I1])
        else $error("compacted map does not start at 0x02");

    chk_compact_v1: assert property (
        compact_read(CMP_V1_HIGH) |=> tx_reg == res_high[CH_V1])
        else $error("voltage 1 high byte not at 0x04 when compacted");

    chk_compact_low: assert property (
        compact_read(OFF_I2_LOW) or compact_read(OFF_V2_LOW)
            |=> tx_reg == 8'h00)
        else $error("low byte reachable in compaction mode");

    chk_read_hold: assert property (
        (state_reg == ST_DATA && !sample_load[CH_V2]) |=> $stable(res_low[CH_V2]))
        else $error("reading changed a stored result");

    chk_miso_shift: assert property (
        (state_reg == ST_DATA && sclk_rise) |=> miso_o == $past(tx_reg[7]))
        else $error("data bit not driven from the transmit byte");

    chk_state_onehot: assert property ($onehot(state_reg))
        else $error("frame state is not one-hot");

endmodule : adc_result_readout

// ==== tb/spi_host_model.sv ====
// Purpose: Host side of the serial control port, one read byte per frame.
// Assumes: Clock mode 1, MSB first, half period of eight system clocks.
// Notes: Pins move only on the falling system clock edge.
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    input wire logic miso_o,
    input wire logic miso_oe,
    output logic sclk,
    output logic select_n,
    output logic mosi
);
    // Eight clocks per half keeps the serial rate at the 8 MHz ceiling or below
    localparam int HALF = 8;

    // Idle pins: clock stands low, data line carries no stale value
    initial begin
        sclk = 1'b0;
        select_n = 1'b1;
        mosi = 1'b0;
    end

    // host-side channel use
    // Every byte is handed back; this host model drops no channel itself
    task automatic xfer(input logic [7:0] abyte, output logic [7:0] rx);
        rx = 8'h00;
        @(negedge clk);
        select_n <= 1'b0;
        repeat (6) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b1;
            // Released data line toggles so no old bit is mistaken for a drive
            mosi <= (i > 7) ? abyte[i - 8] : ~mosi;
            repeat (HALF) @(negedge clk);
            sclk <= 1'b0;
            if (i <= 7) begin
                // Undriven line reads inverted, so a missing enable shows as a bad byte
                rx[i] = miso_oe ? miso_o : ~miso_o;
            end
            repeat (HALF) @(negedge clk);
            if (i == 8) begin
                repeat (HALF) @(negedge clk);
            end
        end
        select_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : spi_host_model

// ==== tb/adc_result_readout_tb.sv ====
// Purpose: Self-checking bench for the result read-back bank.
// Assumes: Inputs move on the falling clock edge, reads go through the host model.
// Notes: Expected bytes come from a private copy of every loaded sample.
`timescale 1ns/1ps
module adc_result_readout_tb;
    import adc_readout_pkg::*;
    logic clk = 1'b0;
    logic resetn;
    logic compact_mode;
    logic [4:0] sample_load;
    logic [23:0] sin [5];
    logic [23:0] samp [5];
    logic sclk;
    logic select_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    int fails = 0;
    int checks = 0;

    // 100 MHz system clock
    always #5 clk = ~clk;

    adc_result_readout u_adc_result_readout (
        .clk(clk), .resetn(resetn), .sclk(sclk), .select_n(select_n),
        .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
        .compact_mode(compact_mode), .sample_load(sample_load),
        .current1_sample(sin[0]), .voltage1_sample(sin[1]),
        .current2_sample(sin[2]), .voltage2_sample(sin[3]),
        .current3_sample(sin[4])
    );

    spi_host_model u_spi_host_model (
        .clk(clk), .miso_o(miso_o), .miso_oe(miso_oe), .sclk(sclk),
        .select_n(select_n), .mosi(mosi)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Byte a correct bank returns at one offset in the current mode
    function automatic logic [7:0] exp_byte(input logic [6:0] off);
        logic [23:0] s;
        logic [7:0] tags [5];
        tags = '{8'h00, voltage1_tag_value, current2_tag_value,
                 voltage2_tag_value, current3_tag_value};
        exp_byte = UNMAPPED_BYTE;
        if (compact_mode) begin
            if (off >= 7'h02 && off <= 7'h0B) begin
                s = samp[(off - 7'h02) >> 1];
                exp_byte = off[0] ? s[15:8] : s[23:16];
            end
        end else if (off >= 7'h05 && off <= 7'h16) begin
            s = samp[(off - 7'h04) >> 2];
            case (off[1:0])
                2'h0: exp_byte = tags[(off - 7'h04) >> 2];
                2'h1: exp_byte = s[23:16];
                2'h2: exp_byte = s[15:8];
                default: exp_byte = s[7:0];
            endcase
        end
    endfunction : exp_byte

    // Read every offset in a range, one frame each
    task automatic sweep(input logic [6:0] lo, input logic [6:0] hi);
        logic [7:0] d;
        for (int a = lo; a <= hi; a++) begin
            u_spi_host_model.xfer({1'b0, 7'(a)}, d);
            check($sformatf("offset %h", a), d, exp_byte(7'(a)));
        end
    endtask : sweep

    // Strobe one channel; others see the inverse so a stray strobe shows.
    // Strobe is left up: the caller lowers it, so back-to-back loads stay legal.
    task automatic load(input int ch, input logic [23:0] v);
        for (int i = 0; i < 5; i++) begin
            sin[i] <= (i == ch) ? v : ~v;
        end
        sample_load <= 5'(1 << ch);
        samp[ch] = v;
        @(negedge clk);
    endtask : load

    task automatic test_reset();
        sweep(7'h05, 7'h16);
        $display("test reset map done");
    endtask : test_reset

    task automatic test_full();
        load(0, 24'hA1B2C3);
        load(1, 24'h1D2E3F);
        load(2, 24'h4A5B6C);
        load(3, 24'h7D8E9F);
        load(4, 24'hF0E1D2);
        sample_load <= 5'h00;
        sweep(7'h05, 7'h16);
        $display("test full map done");
    endtask : test_full

    task automatic test_compact();
        compact_mode <= 1'b1;
        @(negedge clk);
        // tags and low bytes gone, rest packed
        sweep(7'h00, 7'h17);
        compact_mode <= 1'b0;
        @(negedge clk);
        $display("test compact map done");
    endtask : test_compact

    task automatic test_edges();
        load(4, 24'h123456);
        load(4, 24'hFFFFFF);
        load(1, 24'h000001);
        sample_load <= 5'h00;
        // voltage 1 bytes of 0x000001, current 3 high and middle bytes of 0xFFFFFF
        sweep(7'h09, 7'h0B);
        sweep(7'h15, 7'h16);
        $display("test edge values done");
    endtask : test_edges

    task automatic test_no_side();
        logic [7:0] d;
        sweep(7'h0C, 7'h0F);
        u_spi_host_model.xfer(8'h8E, d);
        check("write frame", d, UNMAPPED_BYTE);
        // Deselected: data pin released and cleared
        check("idle pins", {6'h00, miso_oe, miso_o}, 8'h00);
        sweep(7'h0C, 7'h0F);
        sweep(7'h7F, 7'h7F);
        $display("test read side effects done");
    endtask : test_no_side

    // Guard against a hung frame
    initial begin
        for (int n = 0; n < 90000; n++) begin
            @(posedge clk);
        end
        fails++;
        close_out();
    end

    initial begin
        resetn = 1'b0;
        compact_mode = 1'b0;
        sample_load = 5'h00;
        for (int i = 0; i < 5; i++) begin
            sin[i] = 24'h000000;
            samp[i] = RESULT_RESET;
        end
        repeat (4) @(negedge clk);
        resetn <= 1'b1;
        repeat (6) @(negedge clk);
        test_reset();
        test_full();
        test_compact();
        test_edges();
        test_no_side();
        close_out();
    end
endmodule : adc_result_readout_tb
